// *** emergency_drive_mode_control.sv ***
// Purpose: emergency drive mode decode, fault reaction and drive steering
// Assumes: fault and request inputs synchronous to SYS_CLK
// Notes: emergency drive is left only through RESET
`timescale 1ns/100ps
`include "ed_map.svh"
module emergency_drive_mode_control #(
  parameter int unsigned HOLD_CYCLES = `ED_HOLD_S * `ED_CLK_HZ,
  parameter int unsigned TICK_CYCLES = `ED_TICK_MS * (`ED_CLK_HZ / 1000)
) (
  // clock and reset
  input wire logic SYS_CLK,
  input wire logic RESET,
  // register bus
  input wire ed_pkg::apb_req_t APB_REQ,
  output ed_pkg::apb_rsp_t APB_RSP,
  // request and fault sources
  input wire logic EMERGENCY_REQUEST_IN,
  input wire logic FAULT_IN,
  input wire logic FAULT_RETRY_OK,
  // normal commands and pid result
  input wire ed_pkg::drive_t NORMAL_CMD,
  input wire logic [15:0] PID_FREQ_IN,
  // drive side
  output ed_pkg::drive_t DRIVE_CMD,
  output logic PID_ENABLE,
  output logic [15:0] PID_SETPOINT,
  output logic [7:0] PID_FB_SEL,
  output logic OUTPUT_SHUTOFF,
  output logic BYPASS_REQUEST,
  output logic RETRY_RESET,
  output logic FAULT_SHUTOFF_SUPPRESS,
  // status
  output logic EMERGENCY_ACTIVE_OUT,
  output logic FAULT_ALARM_OUT
);
  localparam ed_pkg::ctl_t CTL_RST = '{
    st: ed_pkg::ST_NORMAL,
    mode: `ED_RST_MODE,
    speed: `ED_RST_SPEED,
    limit: `ED_RST_LIMIT,
    wait_t: `ED_RST_WAIT,
    gen: `ED_RST_GEN,
    gwait: `ED_RST_GWAIT,
    default: '0
  };

  ed_pkg::ctl_t s_q;
  ed_pkg::ctl_t s_d;
  logic held;
  logic tmr_done;

  // ==========================================================
  // helpers
  ed_request_qualifier #(
    .HOLD_CYCLES(HOLD_CYCLES)
  ) u_qual (
    .clk(SYS_CLK),
    .rst(RESET),
    .enable(!ed_pkg::decode_mode(s_q.mode).disabled),
    .req(EMERGENCY_REQUEST_IN),
    .held(held)
  );

  ed_retry_timer #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_tmr (
    .clk(SYS_CLK),
    .rst(RESET),
    .start(s_q.tmr_start),
    .load(s_q.tmr_load),
    .done(tmr_done)
  );

  // ==========================================================
  // next state
  always_comb begin
    ed_pkg::mode_t m;
    ed_pkg::mode_t wm;
    logic wr;
    logic lim_hit;
    logic pm;
    logic [7:0] gcnt;
    logic [3:0] gsel;
    logic [13:0] lim14;
    ed_pkg::ed_state_t mains_st;
    m = ed_pkg::decode_mode(s_q.mode);
    wm = ed_pkg::decode_mode(APB_REQ.pwdata[13:0]);
    wr = 1'b0;
    lim_hit = 1'b0;
    pm = s_q.gen[`ED_GEN_PM_BIT];
    gcnt = s_q.gen[`ED_GEN_CNT_LSB +: 8];
    gsel = s_q.gen[`ED_GEN_SEL_LSB +: 4];
    lim14 = {6'h00, s_q.retries};
    mains_st = ed_pkg::ST_BYPASS;
    s_d = s_q;
    s_d.retry_pulse = 1'b0;
    s_d.tmr_start = 1'b0;

    // ----- bus: answer one cycle after setup, no wait states
    s_d.rsp.pready = APB_REQ.psel && !APB_REQ.penable;
    wr = APB_REQ.psel && APB_REQ.penable && s_q.rsp.pready &&
         APB_REQ.pwrite;
    if (APB_REQ.psel && !APB_REQ.penable) begin
      s_d.rsp.prdata = 32'h00000000;
      s_d.rsp.pslverr = 1'b0;
      unique case (APB_REQ.paddr)
        `ED_OFS_MODE: s_d.rsp.prdata[13:0] = s_q.mode;
        `ED_OFS_SPEED: s_d.rsp.prdata[15:0] = s_q.speed;
        `ED_OFS_LIMIT: s_d.rsp.prdata[13:0] = s_q.limit;
        `ED_OFS_WAIT: s_d.rsp.prdata[13:0] = s_q.wait_t;
        `ED_OFS_GEN: s_d.rsp.prdata[20:0] = s_q.gen;
        `ED_OFS_GWAIT: s_d.rsp.prdata[13:0] = s_q.gwait;
        `ED_OFS_STATUS: begin
          s_d.rsp.prdata[0] = s_q.active;
          s_d.rsp.prdata[1] = s_q.st == ed_pkg::ST_WAIT;
          s_d.rsp.prdata[2] = s_q.shutoff;
          s_d.rsp.prdata[3] = s_q.bypass;
          s_d.rsp.prdata[4] = s_q.alarm;
          s_d.rsp.prdata[15:8] = s_q.retries;
        end
        default: s_d.rsp.pslverr = 1'b1;
      endcase
    end

    // ----- bus writes; out-of-range values leave the setting alone, except that mode and gwait check only bits 13:0 and speed and gen are never checked
    if (wr) begin
      unique case (APB_REQ.paddr)
        `ED_OFS_MODE: begin
          if (wm.legal) begin
            s_d.mode = APB_REQ.pwdata[13:0];
          end
        end
        `ED_OFS_SPEED: s_d.speed = APB_REQ.pwdata[15:0];
        `ED_OFS_LIMIT: begin
          if ((APB_REQ.pwdata[13:0] >= 14'h0001 &&
               APB_REQ.pwdata[13:0] <= `ED_LIMIT_MAX &&
               APB_REQ.pwdata[31:14] == 18'h00000) ||
              APB_REQ.pwdata == 32'h0000270F) begin
            s_d.limit = APB_REQ.pwdata[13:0];
          end
        end
        `ED_OFS_WAIT: begin
          if ((APB_REQ.pwdata[13:0] >= `ED_WAIT_MIN &&
               APB_REQ.pwdata[13:0] <= `ED_WAIT_MAX &&
               APB_REQ.pwdata[31:14] == 18'h00000) ||
              APB_REQ.pwdata == 32'h0000270F) begin
            s_d.wait_t = APB_REQ.pwdata[13:0];
          end
        end
        `ED_OFS_GEN: s_d.gen = APB_REQ.pwdata[20:0];
        `ED_OFS_GWAIT: begin
          if (APB_REQ.pwdata[13:0] >= `ED_WAIT_MIN &&
              APB_REQ.pwdata[13:0] <= `ED_WAIT_MAX) begin
            s_d.gwait = APB_REQ.pwdata[13:0];
          end
        end
        default: s_d.gen = s_q.gen;
      endcase
    end

    // ----- retry limit: 3xx unlimited caps at 200, 2xx never caps
    if (s_q.limit == `ED_SETTING_OFF) begin
      lim_hit = (m.react == ed_pkg::RE_RETRY_BYPASS) &&
                (lim14 >= `ED_BYPASS_CAP);
    end else begin
      lim_hit = lim14 >= s_q.limit;
    end
    mains_st = pm ? ed_pkg::ST_SHUTOFF : ed_pkg::ST_BYPASS;

    // ----- emergency sequence
    unique case (s_q.st)
      ed_pkg::ST_NORMAL: begin
        if (held && !m.disabled) begin
          s_d.st = ed_pkg::ST_ACTIVE;
          s_d.shutoff = 1'b0;
          s_d.retries = 8'h00;
        end else if (FAULT_IN) begin
          // outside emergency the general select still applies
          if (gsel != 4'h0 && gcnt != 8'h00 && FAULT_RETRY_OK) begin
            s_d.retry_pulse = 1'b1;
          end else begin
            s_d.shutoff = 1'b1;
          end
        end
      end
      ed_pkg::ST_ACTIVE: begin
        if (FAULT_IN) begin
          unique case (m.react)
            ed_pkg::RE_SHUTOFF: s_d.st = ed_pkg::ST_SHUTOFF;
            ed_pkg::RE_BYPASS: s_d.st = mains_st;
            default: begin
              // general select not consulted here
              if (!FAULT_RETRY_OK || lim_hit) begin
                s_d.st = (m.react == ed_pkg::RE_RETRY_OFF) ?
                         ed_pkg::ST_SHUTOFF : mains_st;
              end else begin
                s_d.st = ed_pkg::ST_WAIT;
                s_d.tmr_start = 1'b1;
                s_d.tmr_load = (s_q.wait_t == `ED_SETTING_OFF) ?
                               s_q.gwait : s_q.wait_t;
                if (s_q.retries != 8'hFF) begin
                  s_d.retries = s_q.retries + 8'h01;
                end
              end
            end
          endcase
        end
      end
      ed_pkg::ST_WAIT: begin
        // faults while the output is already off are not counted
        if (tmr_done) begin
          s_d.st = ed_pkg::ST_ACTIVE;
          s_d.retry_pulse = 1'b1;
        end
      end
      ed_pkg::ST_SHUTOFF: s_d.st = ed_pkg::ST_SHUTOFF;
      ed_pkg::ST_BYPASS: s_d.st = ed_pkg::ST_BYPASS;
      default: s_d.st = ed_pkg::ST_SHUTOFF;
    endcase

    // ----- outputs from the state being entered
    s_d.active = s_d.st != ed_pkg::ST_NORMAL;
    s_d.bypass = s_d.st == ed_pkg::ST_BYPASS;
    if (s_d.st == ed_pkg::ST_SHUTOFF) begin
      s_d.shutoff = 1'b1;
    end
    s_d.pid_en = 1'b0;
    s_d.suppress = 1'b0;
    s_d.drive = NORMAL_CMD;
    if (s_d.st == ed_pkg::ST_ACTIVE) begin
      unique case (m.meth)
        ed_pkg::ME_NORMAL: begin
          s_d.drive = NORMAL_CMD;
          s_d.suppress = 1'b1;
        end
        ed_pkg::ME_FIXED: begin
          s_d.drive.run = 1'b1;
          s_d.drive.reverse = m.reverse;
          s_d.drive.freq = s_q.speed;
        end
        default: begin
          s_d.pid_en = 1'b1;
          s_d.drive.run = 1'b1;
          s_d.drive.reverse = m.reverse;
          s_d.drive.freq = PID_FREQ_IN;
        end
      endcase
    end else if (s_d.st != ed_pkg::ST_NORMAL || s_d.shutoff) begin
      s_d.drive.run = 1'b0;
      s_d.drive.freq = 16'h0000;
    end
    if (s_d.st == ed_pkg::ST_WAIT) begin
      s_d.suppress = 1'b1;
    end

    // ----- alarm held off entirely when general count is zero
    s_d.alarm = (gcnt != 8'h00) &&
                (s_d.shutoff || s_d.bypass);
  end

  // ==========================================================
  // state register
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      s_q <= CTL_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // ==========================================================
  // outputs, all straight from s_q
  assign APB_RSP = s_q.rsp;
  assign DRIVE_CMD = s_q.drive;
  assign PID_ENABLE = s_q.pid_en;
  assign PID_SETPOINT = s_q.speed;
  assign PID_FB_SEL = s_q.gen[`ED_GEN_FB_LSB +: 8];
  assign OUTPUT_SHUTOFF = s_q.shutoff;
  assign BYPASS_REQUEST = s_q.bypass;
  assign RETRY_RESET = s_q.retry_pulse;
  assign FAULT_SHUTOFF_SUPPRESS = s_q.suppress;
  assign EMERGENCY_ACTIVE_OUT = s_q.active;
  assign FAULT_ALARM_OUT = s_q.alarm;
endmodule : emergency_drive_mode_control

// *** ed_map.svh ***
// Purpose: addresses, field positions, reset values and timing counts
// Assumes: 32-bit apb data, one aligned word per register
// Notes: values in 0.1 s units where a wait time is held
`ifndef ED_MAP_SVH
`define ED_MAP_SVH
// ==========================================================
// register byte offsets
`define ED_OFS_MODE 12'h000
`define ED_OFS_SPEED 12'h004
`define ED_OFS_LIMIT 12'h008
`define ED_OFS_WAIT 12'h00C
`define ED_OFS_GEN 12'h010
`define ED_OFS_GWAIT 12'h014
`define ED_OFS_STATUS 12'h018
// ==========================================================
// general config fields
`define ED_GEN_CNT_LSB 0
`define ED_GEN_SEL_LSB 8
`define ED_GEN_FB_LSB 12
`define ED_GEN_PM_BIT 20
// ==========================================================
// reset values and setting limits
`define ED_RST_MODE 14'h270F
`define ED_RST_SPEED 16'h0000
`define ED_RST_LIMIT 14'h0001
`define ED_RST_WAIT 14'h270F
`define ED_RST_GEN 21'h000000
`define ED_RST_GWAIT 14'h000A
`define ED_SETTING_OFF 14'h270F
`define ED_LIMIT_MAX 14'h00C8
`define ED_BYPASS_CAP 14'h00C8
`define ED_WAIT_MIN 14'h0001
`define ED_WAIT_MAX 14'h1770
// ==========================================================
// timing
`define ED_CLK_HZ 200000000
`define ED_HOLD_S 3
`define ED_TICK_MS 100
`endif

// *** ed_pkg.sv ***
// Purpose: types shared by the emergency drive files
// Assumes: mode setting held as a binary value 0..9999
// Notes: decode_mode is used on writes and while running
package ed_pkg;
  // ==========================================================
  // enumerations
  typedef enum logic [2:0] {
    ST_NORMAL, ST_ACTIVE, ST_WAIT, ST_SHUTOFF, ST_BYPASS
  } ed_state_t;
  typedef enum logic [1:0] {
    RE_SHUTOFF, RE_RETRY_OFF, RE_RETRY_BYPASS, RE_BYPASS
  } reaction_t;
  typedef enum logic [1:0] {ME_NORMAL, ME_FIXED, ME_PID} method_t;
  // ==========================================================
  // carriers
  typedef struct packed {
    logic legal;
    logic disabled;
    reaction_t react;
    method_t meth;
    logic reverse;
  } mode_t;
  typedef struct packed {
    logic run;
    logic reverse;
    logic [15:0] freq;
  } drive_t;
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;
  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } apb_rsp_t;
  typedef struct packed {
    ed_state_t st;
    logic [13:0] mode;
    logic [15:0] speed;
    logic [13:0] limit;
    logic [13:0] wait_t;
    logic [20:0] gen;
    logic [13:0] gwait;
    logic [7:0] retries;
    drive_t drive;
    logic pid_en;
    logic shutoff;
    logic bypass;
    logic retry_pulse;
    logic active;
    logic alarm;
    logic suppress;
    logic tmr_start;
    logic [13:0] tmr_load;
    apb_rsp_t rsp;
  } ctl_t;
  // ==========================================================
  // mode setting decode
  function automatic mode_t decode_mode(input logic [13:0] v);
    logic [13:0] h;
    logic [13:0] lo;
    mode_t m;
    h = v / 14'h0064;
    lo = v - 14'(h * 14'h0064);
    m.disabled = (v == 14'h270F);
    m.react = RE_SHUTOFF;
    m.meth = ME_NORMAL;
    m.reverse = 1'b0;
    m.legal = 1'b0;
    unique case (h)
      14'h0001: m.react = RE_SHUTOFF;
      14'h0002: m.react = RE_RETRY_OFF;
      14'h0003: m.react = RE_RETRY_BYPASS;
      default: m.react = RE_BYPASS;
    endcase
    unique case (lo)
      14'h0000: m.meth = ME_NORMAL;
      14'h000B, 14'h000C: m.meth = ME_FIXED;
      default: m.meth = ME_PID;
    endcase
    m.reverse = (lo == 14'h000C) || (lo == 14'h0016);
    if ((h >= 14'h0002) && (h <= 14'h0004)) begin
      m.legal = (lo == 14'h0000) || (lo == 14'h000B) ||
                (lo == 14'h000C) || (lo == 14'h0015) ||
                (lo == 14'h0016);
    end
    if (h == 14'h0001) begin
      m.legal = (lo == 14'h0000);
    end
    if (m.disabled) begin
      m.legal = 1'b1;
    end
    return m;
  endfunction : decode_mode
endpackage : ed_pkg

// *** ed_request_qualifier.sv ***
// Purpose: qualify the emergency request by a continuous hold time
// Assumes: request is synchronous to the clock
// Notes: any drop of the request restarts the hold count
`timescale 1ns/100ps
`include "ed_map.svh"
module ed_request_qualifier #(
  parameter int unsigned HOLD_CYCLES = `ED_HOLD_S * `ED_CLK_HZ
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // request
  input wire logic enable,
  input wire logic req,
  output logic held
);
  typedef struct packed {
    logic [29:0] cnt;
    logic held;
  } qual_t;
  qual_t s_q;
  qual_t s_d;
  // ==========================================================
  // hold counter
  always_comb begin
    s_d = s_q;
    if (!enable || !req) begin
      s_d.cnt = '0;
      s_d.held = 1'b0;
    end else if (s_q.cnt >= 30'(HOLD_CYCLES - 1)) begin
      s_d.held = 1'b1;
    end else begin
      s_d.cnt = s_q.cnt + 30'h00000001;
    end
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
  assign held = s_q.held;
endmodule : ed_request_qualifier

// *** ed_retry_timer.sv ***
// Purpose: retry wait timer counted in 0.1 s ticks
// Assumes: start is a one-cycle pulse, load at least one tick
// Notes: a new start while busy restarts the wait
`timescale 1ns/100ps
`include "ed_map.svh"
module ed_retry_timer #(
  parameter int unsigned TICK_CYCLES = `ED_TICK_MS * (`ED_CLK_HZ / 1000)
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // control
  input wire logic start,
  input wire logic [13:0] load,
  output logic done
);
  typedef struct packed {
    logic [24:0] pre;
    logic [13:0] left;
    logic busy;
    logic done;
  } tmr_t;
  tmr_t s_q;
  tmr_t s_d;
  // ==========================================================
  // prescaler and tick countdown
  always_comb begin
    s_d = s_q;
    s_d.done = 1'b0;
    if (start) begin
      s_d.pre = '0;
      s_d.left = load;
      s_d.busy = 1'b1;
    end else if (s_q.busy) begin
      if (s_q.pre >= 25'(TICK_CYCLES - 1)) begin
        s_d.pre = '0;
        if (s_q.left <= 14'h0001) begin
          s_d.busy = 1'b0;
          s_d.done = 1'b1;
        end else begin
          s_d.left = s_q.left - 14'h0001;
        end
      end else begin
        s_d.pre = s_q.pre + 25'h0000001;
      end
    end
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
  assign done = s_q.done;
endmodule : ed_retry_timer

// *** emergency_drive_mode_control_chk.sv ***
// Purpose: port assertions for the emergency drive control block
// Assumes: one clock, synchronous active-high reset
// Notes: bound to every instance of the top module
`timescale 1ns/100ps
// ==========================================================
// checker
module emergency_drive_mode_control_chk (
  // clock and reset
  input wire logic SYS_CLK,
  input wire logic RESET,
  // bus
  input wire ed_pkg::apb_req_t APB_REQ,
  input wire ed_pkg::apb_rsp_t APB_RSP,
  // sources
  input wire logic EMERGENCY_REQUEST_IN,
  input wire logic FAULT_IN,
  // outputs
  input wire logic PID_ENABLE,
  input wire logic OUTPUT_SHUTOFF,
  input wire logic BYPASS_REQUEST,
  input wire logic RETRY_RESET,
  input wire logic EMERGENCY_ACTIVE_OUT,
  input wire logic FAULT_ALARM_OUT
);
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RESET);
  active_hold_a: assert property (
    EMERGENCY_ACTIVE_OUT |=> EMERGENCY_ACTIVE_OUT)
    else $error("active dropped");
  entry_cause_a: assert property (
    $rose(EMERGENCY_ACTIVE_OUT) |-> $past(EMERGENCY_REQUEST_IN, 2))
    else $error("entry without request");
  shut_hold_a: assert property (
    OUTPUT_SHUTOFF && EMERGENCY_ACTIVE_OUT |=> OUTPUT_SHUTOFF)
    else $error("shutoff dropped");
  shut_cause_a: assert property (
    $rose(OUTPUT_SHUTOFF) |-> $past(FAULT_IN))
    else $error("shutoff without fault");
  bypass_hold_a: assert property (
    BYPASS_REQUEST |=> BYPASS_REQUEST)
    else $error("bypass dropped");
  bypass_cause_a: assert property (
    $rose(BYPASS_REQUEST) |-> $past(FAULT_IN) && EMERGENCY_ACTIVE_OUT)
    else $error("bypass without fault");
  shut_bypass_excl_a: assert property (
    !(OUTPUT_SHUTOFF && BYPASS_REQUEST))
    else $error("shutoff and bypass together");
  alarm_gate_a: assert property (
    FAULT_ALARM_OUT |-> OUTPUT_SHUTOFF || BYPASS_REQUEST)
    else $error("alarm without stop");
  pid_gate_a: assert property (
    PID_ENABLE |-> EMERGENCY_ACTIVE_OUT)
    else $error("pid outside emergency");
  retry_pulse_a: assert property (
    RETRY_RESET |=> !RETRY_RESET)
    else $error("retry pulse too long");
  apb_answer_a: assert property (
    APB_REQ.psel && !APB_REQ.penable |=> APB_RSP.pready)
    else $error("no ready after setup");
endmodule : emergency_drive_mode_control_chk
bind emergency_drive_mode_control emergency_drive_mode_control_chk chk_i (
  .SYS_CLK(SYS_CLK), .RESET(RESET), .APB_REQ(APB_REQ), .APB_RSP(APB_RSP),
  .EMERGENCY_REQUEST_IN(EMERGENCY_REQUEST_IN), .FAULT_IN(FAULT_IN),
  .PID_ENABLE(PID_ENABLE), .OUTPUT_SHUTOFF(OUTPUT_SHUTOFF),
  .BYPASS_REQUEST(BYPASS_REQUEST), .RETRY_RESET(RETRY_RESET),
  .EMERGENCY_ACTIVE_OUT(EMERGENCY_ACTIVE_OUT),
  .FAULT_ALARM_OUT(FAULT_ALARM_OUT));

// *** drive_stage_model.sv ***
// Purpose: power stage and control inputs seen by the block
// Assumes: bench commands change at the rising edge
// Notes: retry permission is noise outside a fault pulse
`timescale 1ns/100ps
// ==========================================================
// model
module drive_stage_model (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // bench commands
  input wire logic fire,
  input wire logic ok_in,
  input wire logic req_on,
  // toward the block
  output logic fault_pulse = 1'b0,
  output logic retry_ok,
  output logic request = 1'b0,
  output logic [15:0] pid_freq = 16'hACE1
);
  logic ok_q = 1'b0;
  always @(posedge clk) begin
    fault_pulse <= fire & ~rst;
    ok_q <= ok_in;
    request <= req_on & ~rst;
    pid_freq <= {pid_freq[14:0], pid_freq[15] ^ pid_freq[13]};
  end
  // never a stale level, so a late sample cannot pass by luck
  assign retry_ok = fault_pulse ? ok_q : pid_freq[0];
endmodule : drive_stage_model

// *** emergency_drive_mode_control_tb_top.sv ***
// Purpose: self-checking bench for emergency drive control
// Assumes: short hold and tick counts for a quick run
// Notes: each mode case starts from reset, since entry is sticky
`timescale 1ns/100ps
`include "ed_map.svh"
module emergency_drive_mode_control_tb_top;
  localparam int HOLD = 20;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  ed_pkg::apb_req_t apb_req = '0;
  ed_pkg::apb_rsp_t apb_rsp;
  ed_pkg::drive_t normal_cmd = '0;
  ed_pkg::drive_t drive_cmd;
  logic fire = 1'b0;
  logic ok_in = 1'b0;
  logic req_on = 1'b0;
  logic fault_in, retry_ok, request, pid_en, shutoff, bypass;
  logic retry_rst, suppress, active, alarm, rerr;
  logic [15:0] pid_freq, pid_sp;
  logic [7:0] fb_sel;
  logic [31:0] rd;
  int err_total = 0;
  int n_compared = 0;
  int exp_reg [7];
  always #2.5 sys_clk = ~sys_clk;
  emergency_drive_mode_control #(.HOLD_CYCLES(HOLD), .TICK_CYCLES(4)) dut (
    .SYS_CLK(sys_clk), .RESET(reset), .APB_REQ(apb_req), .APB_RSP(apb_rsp),
    .EMERGENCY_REQUEST_IN(request), .FAULT_IN(fault_in),
    .FAULT_RETRY_OK(retry_ok), .NORMAL_CMD(normal_cmd),
    .PID_FREQ_IN(pid_freq), .DRIVE_CMD(drive_cmd), .PID_ENABLE(pid_en),
    .PID_SETPOINT(pid_sp), .PID_FB_SEL(fb_sel), .OUTPUT_SHUTOFF(shutoff),
    .BYPASS_REQUEST(bypass), .RETRY_RESET(retry_rst),
    .FAULT_SHUTOFF_SUPPRESS(suppress), .EMERGENCY_ACTIVE_OUT(active),
    .FAULT_ALARM_OUT(alarm));
  drive_stage_model stage (.clk(sys_clk), .rst(reset), .fire(fire),
    .ok_in(ok_in), .req_on(req_on), .fault_pulse(fault_in),
    .retry_ok(retry_ok), .request(request), .pid_freq(pid_freq));
  // ==========================================================
  // tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic summarize;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : summarize
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : tick
  task automatic apb(input logic w, input logic [11:0] a, input int d);
    int n;
    n = 0;
    @(posedge sys_clk);
    apb_req <= '{psel:1'b1, penable:1'b0, pwrite:w, paddr:a, pwdata:d};
    @(posedge sys_clk);
    apb_req.penable <= 1'b1;
    // look mid-cycle so the value seen is the one the next edge samples
    do begin
      @(negedge sys_clk);
      n++;
    end while (apb_rsp.pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      err_total++;
    end
    rd = apb_rsp.prdata;
    rerr = apb_rsp.pslverr;
    @(posedge sys_clk);
    apb_req.psel <= 1'b0;
    apb_req.penable <= 1'b0;
  endtask : apb
  task automatic rst;
    @(posedge sys_clk);
    reset <= 1'b1;
    req_on <= 1'b0;
    repeat (10) @(posedge sys_clk);
    reset <= 1'b0;
    exp_reg = '{32'h270F, 0, 1, 32'h270F, 0, 32'hA, 0};
  endtask : rst
  task automatic enter;
    int n;
    n = 0;
    req_on <= 1'b1;
    while (active !== 1'b1 && n < HOLD + 40) begin
      tick(1);
      n++;
    end
    chk(active, 1'b1);
  endtask : enter
  task automatic fault(input logic ok);
    @(posedge sys_clk);
    fire <= 1'b1;
    ok_in <= ok;
    @(posedge sys_clk);
    fire <= 1'b0;
    tick(3);
  endtask : fault
  task automatic run_mode(input int m, input int gen, input int lim,
      input logic ok, input int nf, input logic e_shut, input logic e_byp);
    logic [15:0] sp;
    int meth;
    logic e_alm;
    int n;
    sp = 16'($urandom);
    meth = m % 100;
    e_alm = (gen[7:0] != 0) && (e_shut || e_byp);
    rst;
    apb(1'b1, `ED_OFS_MODE, m);
    apb(1'b1, `ED_OFS_SPEED, sp);
    apb(1'b1, `ED_OFS_LIMIT, lim);
    apb(1'b1, `ED_OFS_WAIT, 1);
    apb(1'b1, `ED_OFS_GEN, gen);
    normal_cmd <= '{run:1'b0, reverse:1'($urandom), freq:16'($urandom)};
    enter;
    if (meth == 0) begin
      chk(drive_cmd, normal_cmd);
      chk(suppress, 1'b1);
    end else begin
      chk(drive_cmd.run, 1'b1);
      chk(drive_cmd.reverse, meth % 10 == 2);
      chk(pid_en, meth > 20);
      if (meth < 20) begin
        chk(drive_cmd.freq, sp);
      end else begin
        chk(pid_sp, sp);
        chk(fb_sel, gen[19:12]);
      end
    end
    for (int i = 1; i < nf; i++) begin
      fault(ok);
      chk(suppress, 1'b1);
      n = 0;
      while (retry_rst !== 1'b1 && n < 200) begin
        tick(1);
        n++;
      end
      chk(retry_rst, 1'b1);
      chk(drive_cmd.run, meth != 0);
      chk(bypass, 1'b0);
    end
    fault(ok);
    chk(shutoff, e_shut);
    chk(bypass, e_byp);
    chk(alarm, e_alm);
    apb(1'b0, `ED_OFS_STATUS, 0);
    chk(rd[4:0], {e_alm, e_byp, e_shut, 1'b0, 1'b1});
    $display("test mode %0d done", m);
  endtask : run_mode
  // ==========================================================
  // sequence
  initial begin
    #200000;
    err_total++;
    summarize;
  end
  initial begin
    void'($urandom(87622));
    rst;
    foreach (exp_reg[i]) begin
      apb(1'b0, 12'(i * 4), 0);
      chk(rd, exp_reg[i]);
    end
    apb(1'b1, `ED_OFS_LIMIT, 32'hC8);
    apb(1'b1, `ED_OFS_LIMIT, 32'hC9);
    apb(1'b0, `ED_OFS_LIMIT, 0);
    chk(rd, 32'hC8);
    apb(1'b1, `ED_OFS_WAIT, 32'h1770);
    apb(1'b1, `ED_OFS_WAIT, 32'h1771);
    apb(1'b0, `ED_OFS_WAIT, 0);
    chk(rd, 32'h1770);
    apb(1'b0, 12'h040, 0);
    chk(rerr, 1'b1);
    req_on <= 1'b1;
    tick(3 * HOLD);
    chk(active, 1'b0);
    apb(1'b1, `ED_OFS_MODE, 211);
    req_on <= 1'b0;
    @(posedge sys_clk);
    req_on <= 1'b1;
    tick(HOLD - 4);
    chk(active, 1'b0);
    enter;
    @(posedge sys_clk);
    req_on <= 1'b0;
    tick(5);
    chk(active, 1'b1);
    $display("test entry done");
    run_mode(100, 32'h0, 1, 1'b1, 1, 1'b1, 1'b0);
    run_mode(211, 32'h101, 2, 1'b1, 3, 1'b1, 1'b0);
    run_mode(312, 32'h1, 5, 1'b0, 1, 1'b0, 1'b1);
    run_mode(421, 32'h5A001, 1, 1'b1, 1, 1'b0, 1'b1);
    run_mode(422, 32'h100001, 1, 1'b1, 1, 1'b1, 1'b0);
    run_mode(300, 32'h1, 9999, 1'b1, 201, 1'b0, 1'b1);
    summarize;
  end
endmodule : emergency_drive_mode_control_tb_top
